//--- src/plg_power_limit_regs.sv
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - compare each new sense result against high and low limits
// - sense at/above high or below low sets its flag and asserts alarm
// - sense comparisons are signed, negative readings included
// - sense limits compare against result bits 11-4, one limit step is 16 result counts
// - source at/above high or below low sets its flag and asserts alarm
// - value at/above its critical limit drives critical low, sets flag
// - critical holds until value below limit minus hysteresis; hyst resets 10
// - direction bit: 0 input (reset), 1 output
// - output-level bit drives pin when output, ignored as input, resets 0
// - mirror bit shows pin level; change as input sets change flag
// - cleared change mask lets input changes assert alarm; set at reset
// - straps captured at power-up into features bits 7-4 and 3-0
// - captured threshold strap is reset value of peak threshold field
// - captured duration strap is reset value of peak duration field
// - variant without straps reads features as zero
// - three read-only identity bytes at the top three addresses
// - sense results are 12-bit two's complement, sign gives direction
// - host write to peak config replaces strap values until the next reset
module plg_power_limit_regs #(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h2A,
  parameter bit         HAS_STRAPS     = 1'b1,
  // identity values are arbitrary
  parameter logic [7:0] PART_CODE      = 8'hA5,
  parameter logic [7:0] MAKER_CODE     = 8'h5A,
  parameter logic [7:0] DIE_REVISION   = 8'h01
) (
  // system clock domain
  input  wire logic                  i_clock,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_clock_en,
  // link clock domain
  input  wire logic                  i_link_clock,
  // two-wire management bus, open drain
  input  wire logic                  i_scl,
  output logic                       o_scl_out,
  output logic                       o_scl_oe,
  input  wire logic                  i_sda,
  output logic                       o_sda_out,
  output logic                       o_sda_oe,
  // converter results
  input  wire plg_pkg::plg_meas_t    i_meas,
  // status flags
  output var  plg_pkg::plg_flags_t   o_flags,
  input  wire plg_pkg::plg_flags_t   i_flag_clear,
  // alarms
  output logic                       o_alert_n,
  output logic                       o_critical_out_n,
  // general purpose pin
  input  wire logic                  i_pin,
  output logic                       o_pin_out,
  output logic                       o_pin_oe,
  // straps
  input  wire logic [3:0]            i_threshold_strap,
  input  wire logic [3:0]            i_duration_strap,
  // peak detector settings
  output logic [3:0]                 o_peak_threshold_field,
  output logic [3:0]                 o_peak_duration_field
);

  plg_pkg::plg_sys_state_t  r;
  plg_pkg::plg_sys_state_t  n;
  plg_pkg::plg_link_state_t l;
  plg_pkg::plg_link_state_t ln;

  // compare values in 10 bits, sense sign extended, source zero extended
  logic [7:0]        sense_hi;
  logic [7:0]        source_hi;
  logic signed [9:0] sense_val;
  logic signed [9:0] sense_release;
  logic signed [9:0] source_val;
  logic signed [9:0] source_release;

  assign sense_hi  = i_meas.sense_result[11:4];
  assign source_hi = i_meas.source_result[10:3];
  assign sense_val = $signed({{2{sense_hi[7]}}, sense_hi});
  assign sense_release = $signed({{2{r.sense_crit[7]}}, r.sense_crit})
                       - $signed({5'h00, r.sense_hyst});
  assign source_val = $signed({2'h0, source_hi});
  // an unsigned limit below its hysteresis goes negative and never releases
  assign source_release = $signed({2'h0, r.source_crit})
                        - $signed({5'h00, r.source_hyst});

  function automatic logic [7:0] read_byte(input logic [7:0]              addr,
                                           input plg_pkg::plg_sys_state_t s);
    logic [7:0] v;
    v = plg_pkg::UNMAPPED_READ;
    unique case (addr)
      plg_pkg::SENSE_HIGH_LIMIT_OFFSET:  v = s.sense_high;
      plg_pkg::SENSE_LOW_LIMIT_OFFSET:   v = s.sense_low;
      plg_pkg::SOURCE_HIGH_LIMIT_OFFSET: v = s.source_high;
      plg_pkg::SOURCE_LOW_LIMIT_OFFSET:  v = s.source_low;
      plg_pkg::SENSE_CRIT_LIMIT_OFFSET:  v = s.sense_crit;
      plg_pkg::SOURCE_CRIT_LIMIT_OFFSET: v = s.source_crit;
      plg_pkg::SENSE_CRIT_HYST_OFFSET:   v = {3'h0, s.sense_hyst};
      plg_pkg::SOURCE_CRIT_HYST_OFFSET:  v = {3'h0, s.source_hyst};
      plg_pkg::PIN_CONFIG_OFFSET:
        v = {4'h0, s.pin_change_mask, s.pin_s2, s.pin_out, s.pin_dir};
      plg_pkg::PEAK_CONFIG_OFFSET:       v = {s.peak_th, s.peak_dur};
      plg_pkg::STRAP_FEATURES_OFFSET:    v = s.features;
      plg_pkg::PART_CODE_OFFSET:         v = PART_CODE;
      plg_pkg::MAKER_CODE_OFFSET:        v = MAKER_CODE;
      plg_pkg::DIE_REVISION_OFFSET:      v = DIE_REVISION;
      default:                           v = plg_pkg::UNMAPPED_READ;
    endcase
    return v;
  endfunction

  // system domain: registers, limit checks, pin, straps
  always_comb begin
    n = r;
    n.pin_s1   = i_pin;
    n.pin_s2   = r.pin_s1;
    n.pin_prev = r.pin_s2;
    n.strap_s1 = {i_threshold_strap, i_duration_strap};
    n.strap_s2 = r.strap_s1;
    n.req_s1   = l.req_tgl;
    n.req_s2   = r.req_s1;

    // the strap levels settle through the synchroniser before capture
    if (!r.strap_done) begin
      if (r.strap_cnt == plg_pkg::STRAP_SETTLE_CYCLES) begin
        n.strap_done = 1'h1;
        if (HAS_STRAPS) begin
          n.features = r.strap_s2;
          if (!r.peak_written) begin
            n.peak_th  = r.strap_s2[7:4];
            n.peak_dur = r.strap_s2[3:0];
          end
        end
      end else begin
        n.strap_cnt = r.strap_cnt + 2'h1;
      end
    end

    // clear first so that a same-cycle event still sets the flag
    n.flags = plg_pkg::plg_flags_t'(r.flags & ~i_flag_clear);

    if (i_meas.sense_valid) begin
      if ($signed(sense_hi) >= $signed(r.sense_high)) begin
        n.flags.sense_over_flag = 1'h1;
      end
      if ($signed(sense_hi) < $signed(r.sense_low)) begin
        n.flags.sense_under_flag = 1'h1;
      end
      if ($signed(sense_hi) >= $signed(r.sense_crit)) begin
        n.sense_crit_on = 1'h1;
        n.flags.sense_crit_flag = 1'h1;
      end else if (sense_val < sense_release) begin
        n.sense_crit_on = 1'h0;
      end
    end

    if (i_meas.source_valid) begin
      if (source_hi >= r.source_high) begin
        n.flags.source_over_flag = 1'h1;
      end
      if (source_hi < r.source_low) begin
        n.flags.source_under_flag = 1'h1;
      end
      if (source_hi >= r.source_crit) begin
        n.source_crit_on = 1'h1;
        n.flags.source_crit_flag = 1'h1;
      end else if (source_val < source_release) begin
        n.source_crit_on = 1'h0;
      end
    end

    if (!r.pin_dir && (r.pin_s2 != r.pin_prev)) begin
      n.flags.pin_change_flag = 1'h1;
    end

    // register access requested by the link side
    if (r.req_s2 != r.req_seen) begin
      n.req_seen = r.req_s2;
      n.ack_tgl  = ~r.ack_tgl;
      if (l.req_write) begin
        unique case (l.req_addr)
          plg_pkg::SENSE_HIGH_LIMIT_OFFSET:  n.sense_high  = l.req_data;
          plg_pkg::SENSE_LOW_LIMIT_OFFSET:   n.sense_low   = l.req_data;
          plg_pkg::SOURCE_HIGH_LIMIT_OFFSET: n.source_high = l.req_data;
          plg_pkg::SOURCE_LOW_LIMIT_OFFSET:  n.source_low  = l.req_data;
          plg_pkg::SENSE_CRIT_LIMIT_OFFSET:  n.sense_crit  = l.req_data;
          plg_pkg::SOURCE_CRIT_LIMIT_OFFSET: n.source_crit = l.req_data;
          plg_pkg::SENSE_CRIT_HYST_OFFSET:   n.sense_hyst  = l.req_data[4:0];
          plg_pkg::SOURCE_CRIT_HYST_OFFSET:  n.source_hyst = l.req_data[4:0];
          plg_pkg::PIN_CONFIG_OFFSET: begin
            n.pin_dir         = l.req_data[plg_pkg::PIN_DIR_BIT];
            n.pin_out         = l.req_data[plg_pkg::PIN_OUT_BIT];
            n.pin_change_mask = l.req_data[plg_pkg::PIN_MASK_BIT];
          end
          plg_pkg::PEAK_CONFIG_OFFSET: begin
            n.peak_th      = l.req_data[7:4];
            n.peak_dur     = l.req_data[3:0];
            n.peak_written = 1'h1;
          end
          default: begin
          end
        endcase
      end else begin
        n.rdata = read_byte(l.req_addr, r);
      end
    end

    n.alert_n = ~(n.flags.sense_over_flag | n.flags.sense_under_flag
                | n.flags.source_over_flag | n.flags.source_under_flag
                | (n.flags.pin_change_flag & ~r.pin_change_mask
                   & ~r.pin_dir));
    n.crit_n  = ~(n.sense_crit_on | n.source_crit_on);
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      r <= plg_pkg::SYS_RESET;
    end else if (i_clock_en) begin
      r <= n;
    end
  end

  // link domain: two-wire slave, oversampling the bus on the link clock
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic ack_edge;

  assign scl_rise  = l.scl_s2 & ~l.scl_prev;
  assign scl_fall  = ~l.scl_s2 & l.scl_prev;
  assign bus_start = l.scl_s2 & l.scl_prev & l.sda_prev & ~l.sda_s2;
  assign bus_stop  = l.scl_s2 & l.scl_prev & ~l.sda_prev & l.sda_s2;
  assign ack_edge  = l.ack_s2 != l.ack_seen;

  always_comb begin
    ln = l;
    ln.scl_s1   = i_scl;
    ln.scl_s2   = l.scl_s1;
    ln.scl_prev = l.scl_s2;
    ln.sda_s1   = i_sda;
    ln.sda_s2   = l.sda_s1;
    ln.sda_prev = l.sda_s2;
    ln.rst_s1   = i_sys_rst;
    ln.rst_s2   = l.rst_s1;
    ln.ack_s1   = r.ack_tgl;
    ln.ack_s2   = l.ack_s1;
    if (l.rst_s2) begin
      ln.fsm      = plg_pkg::ST_IDLE;
      ln.cnt      = 4'h0;
      ln.sh       = 8'h00;
      ln.ptr      = 8'h00;
      ln.sda_oe   = 1'h0;
      ln.scl_oe   = 1'h0;
      ln.req_tgl  = 1'h0;
      ln.ack_seen = 1'h0;
    end else begin
      if (ack_edge) begin
        ln.ack_seen = l.ack_s2;
      end
      if (bus_start) begin
        ln.fsm    = plg_pkg::ST_RX_ADDR;
        ln.cnt    = 4'h0;
        ln.sda_oe = 1'h0;
      end else if (bus_stop) begin
        ln.fsm    = plg_pkg::ST_IDLE;
        ln.sda_oe = 1'h0;
      end else begin
        unique case (l.fsm)
          plg_pkg::ST_IDLE: begin
          end
          plg_pkg::ST_RX_ADDR, plg_pkg::ST_RX_CMD,
          plg_pkg::ST_RX_DATA: begin
            if (scl_rise) begin
              ln.sh  = {l.sh[6:0], l.sda_s2};
              ln.cnt = l.cnt + 4'h1;
            end else if (scl_fall && l.cnt == 4'h8) begin
              ln.sda_oe = 1'h1;
              if (l.fsm == plg_pkg::ST_RX_ADDR) begin
                if (l.sh[7:1] == DEVICE_ADDRESS) begin
                  ln.fsm = plg_pkg::ST_ACK_ADDR;
                end else begin
                  ln.fsm    = plg_pkg::ST_IDLE;
                  ln.sda_oe = 1'h0;
                end
              end else if (l.fsm == plg_pkg::ST_RX_CMD) begin
                ln.ptr = l.sh;
                ln.fsm = plg_pkg::ST_ACK_CMD;
              end else begin
                // hold the clock low until the write has landed
                ln.req_write = 1'h1;
                ln.req_addr  = l.ptr;
                ln.req_data  = l.sh;
                ln.req_tgl   = ~l.req_tgl;
                ln.scl_oe    = 1'h1;
                ln.fsm       = plg_pkg::ST_WAIT_WR;
              end
            end
          end
          plg_pkg::ST_ACK_ADDR: begin
            if (scl_fall) begin
              ln.sda_oe = 1'h0;
              ln.cnt    = 4'h0;
              if (l.sh[0]) begin
                ln.req_write = 1'h0;
                ln.req_addr  = l.ptr;
                ln.req_tgl   = ~l.req_tgl;
                ln.scl_oe    = 1'h1;
                ln.fsm       = plg_pkg::ST_FETCH;
              end else begin
                ln.fsm = plg_pkg::ST_RX_CMD;
              end
            end
          end
          plg_pkg::ST_ACK_CMD, plg_pkg::ST_ACK_DATA: begin
            if (scl_fall) begin
              ln.sda_oe = 1'h0;
              ln.cnt    = 4'h0;
              ln.fsm    = plg_pkg::ST_RX_DATA;
            end
          end
          plg_pkg::ST_WAIT_WR: begin
            if (ack_edge) begin
              ln.scl_oe = 1'h0;
              ln.ptr    = l.ptr + 8'h01;
              ln.fsm    = plg_pkg::ST_ACK_DATA;
            end
          end
          plg_pkg::ST_FETCH: begin
            if (ack_edge) begin
              ln.sh     = r.rdata;
              ln.sda_oe = ~r.rdata[7];
              ln.cnt    = 4'h1;
              ln.scl_oe = 1'h0;
              ln.ptr    = l.ptr + 8'h01;
              ln.fsm    = plg_pkg::ST_TX;
            end
          end
          plg_pkg::ST_TX: begin
            if (scl_fall) begin
              if (l.cnt == 4'h8) begin
                ln.sda_oe = 1'h0;
                ln.fsm    = plg_pkg::ST_TX_ACK;
              end else begin
                ln.sh     = {l.sh[6:0], 1'h0};
                ln.sda_oe = ~l.sh[6];
                ln.cnt    = l.cnt + 4'h1;
              end
            end
          end
          plg_pkg::ST_TX_ACK: begin
            if (scl_rise) begin
              ln.fsm = l.sda_s2 ? plg_pkg::ST_IDLE : plg_pkg::ST_TX_ACK2;
            end
          end
          plg_pkg::ST_TX_ACK2: begin
            if (scl_fall) begin
              ln.req_write = 1'h0;
              ln.req_addr  = l.ptr;
              ln.req_tgl   = ~l.req_tgl;
              ln.scl_oe    = 1'h1;
              ln.fsm       = plg_pkg::ST_FETCH;
            end
          end
          default: begin
            ln.fsm = plg_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_link_clock) begin
    l <= ln;
  end

  assign o_scl_out              = 1'h0;
  assign o_scl_oe               = l.scl_oe;
  assign o_sda_out              = 1'h0;
  assign o_sda_oe               = l.sda_oe;
  assign o_flags                = r.flags;
  assign o_alert_n              = r.alert_n;
  assign o_critical_out_n       = r.crit_n;
  assign o_pin_out              = r.pin_out;
  assign o_pin_oe               = r.pin_dir;
  assign o_peak_threshold_field = r.peak_th;
  assign o_peak_duration_field  = r.peak_dur;

endmodule

`default_nettype wire

//--- src/plg_pkg.sv
`default_nettype none
package plg_pkg;

  // register offsets
  localparam logic [7:0] SENSE_HIGH_LIMIT_OFFSET  = 8'h60;
  localparam logic [7:0] SENSE_LOW_LIMIT_OFFSET   = 8'h61;
  localparam logic [7:0] SOURCE_HIGH_LIMIT_OFFSET = 8'h64;
  localparam logic [7:0] SOURCE_LOW_LIMIT_OFFSET  = 8'h65;
  localparam logic [7:0] SENSE_CRIT_LIMIT_OFFSET  = 8'h66;
  localparam logic [7:0] SOURCE_CRIT_LIMIT_OFFSET = 8'h68;
  localparam logic [7:0] SENSE_CRIT_HYST_OFFSET   = 8'h69;
  localparam logic [7:0] SOURCE_CRIT_HYST_OFFSET  = 8'h6A;
  localparam logic [7:0] PIN_CONFIG_OFFSET        = 8'h70;
  localparam logic [7:0] PEAK_CONFIG_OFFSET       = 8'h4F;
  localparam logic [7:0] STRAP_FEATURES_OFFSET    = 8'hFC;
  localparam logic [7:0] PART_CODE_OFFSET         = 8'hFD;
  localparam logic [7:0] MAKER_CODE_OFFSET        = 8'hFE;
  localparam logic [7:0] DIE_REVISION_OFFSET      = 8'hFF;

  // values after reset
  localparam logic [7:0] SENSE_HIGH_LIMIT_RESET  = 8'h7F;
  localparam logic [7:0] SENSE_LOW_LIMIT_RESET   = 8'h80;
  localparam logic [7:0] SOURCE_HIGH_LIMIT_RESET = 8'hFF;
  localparam logic [7:0] SOURCE_LOW_LIMIT_RESET  = 8'h00;
  localparam logic [7:0] SENSE_CRIT_LIMIT_RESET  = 8'h7F;
  localparam logic [7:0] SOURCE_CRIT_LIMIT_RESET = 8'hFF;
  localparam logic [4:0] CRIT_HYST_RESET         = 5'h0A;
  localparam logic [7:0] PIN_CONFIG_RESET        = 8'h08;
  localparam logic [7:0] FEATURES_NONE           = 8'h00;
  localparam logic [7:0] UNMAPPED_READ           = 8'h00;

  // pin_config field positions
  localparam int PIN_DIR_BIT  = 0;
  localparam int PIN_OUT_BIT  = 1;
  localparam int PIN_IN_BIT   = 2;
  localparam int PIN_MASK_BIT = 3;

  // cycles after reset release before the strap levels are taken
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

  typedef struct packed {
    logic        sense_valid;
    logic [11:0] sense_result;
    logic        source_valid;
    logic [10:0] source_result;
  } plg_meas_t;

  typedef struct packed {
    logic sense_over_flag;
    logic sense_under_flag;
    logic source_over_flag;
    logic source_under_flag;
    logic sense_crit_flag;
    logic source_crit_flag;
    logic pin_change_flag;
  } plg_flags_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_RX_ADDR, ST_ACK_ADDR, ST_RX_CMD, ST_ACK_CMD, ST_RX_DATA,
    ST_WAIT_WR, ST_ACK_DATA, ST_FETCH, ST_TX, ST_TX_ACK, ST_TX_ACK2
  } plg_link_fsm_t;

  // whole state of the system-clock side
  typedef struct packed {
    logic [7:0] sense_high;
    logic [7:0] sense_low;
    logic [7:0] source_high;
    logic [7:0] source_low;
    logic [7:0] sense_crit;
    logic [7:0] source_crit;
    logic [4:0] sense_hyst;
    logic [4:0] source_hyst;
    logic       pin_dir;
    logic       pin_out;
    logic       pin_change_mask;
    logic       pin_s1;
    logic       pin_s2;
    logic       pin_prev;
    logic [7:0] strap_s1;
    logic [7:0] strap_s2;
    logic [7:0] features;
    logic [1:0] strap_cnt;
    logic       strap_done;
    logic       peak_written;
    logic [3:0] peak_th;
    logic [3:0] peak_dur;
    plg_flags_t flags;
    logic       sense_crit_on;
    logic       source_crit_on;
    logic       alert_n;
    logic       crit_n;
    logic       req_s1;
    logic       req_s2;
    logic       req_seen;
    logic       ack_tgl;
    logic [7:0] rdata;
  } plg_sys_state_t;

  // whole state of the link-clock side
  typedef struct packed {
    logic          scl_s1;
    logic          scl_s2;
    logic          scl_prev;
    logic          sda_s1;
    logic          sda_s2;
    logic          sda_prev;
    logic          rst_s1;
    logic          rst_s2;
    logic          ack_s1;
    logic          ack_s2;
    logic          ack_seen;
    plg_link_fsm_t fsm;
    logic [3:0]    cnt;
    logic [7:0]    sh;
    logic [7:0]    ptr;
    logic          sda_oe;
    logic          scl_oe;
    logic          req_tgl;
    logic          req_write;
    logic [7:0]    req_addr;
    logic [7:0]    req_data;
  } plg_link_state_t;

  localparam plg_sys_state_t SYS_RESET = '{
    sense_high:      SENSE_HIGH_LIMIT_RESET,
    sense_low:       SENSE_LOW_LIMIT_RESET,
    source_high:     SOURCE_HIGH_LIMIT_RESET,
    source_low:      SOURCE_LOW_LIMIT_RESET,
    sense_crit:      SENSE_CRIT_LIMIT_RESET,
    source_crit:     SOURCE_CRIT_LIMIT_RESET,
    sense_hyst:      CRIT_HYST_RESET,
    source_hyst:     CRIT_HYST_RESET,
    pin_dir:         PIN_CONFIG_RESET[PIN_DIR_BIT],
    pin_out:         PIN_CONFIG_RESET[PIN_OUT_BIT],
    pin_change_mask: PIN_CONFIG_RESET[PIN_MASK_BIT],
    features:        FEATURES_NONE,
    alert_n:         1'h1,
    crit_n:          1'h1,
    default:         '0
  };

endpackage
`default_nettype wire

//--- verification/plg_chk.sv
`timescale 1ns/1ns
`default_nettype none
module plg_chk (
  // system side
  input wire logic                i_clock,
  input wire logic                i_sys_rst,
  input wire plg_pkg::plg_meas_t  i_meas,
  input wire plg_pkg::plg_flags_t i_flag_clear,
  // watched outputs
  input wire plg_pkg::plg_flags_t o_flags,
  input wire logic                o_alert_n,
  input wire logic                o_critical_out_n,
  input wire logic                o_pin_out,
  input wire logic                o_pin_oe
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sense_alert_a: assert property (
    o_flags.sense_over_flag || o_flags.sense_under_flag |-> !o_alert_n)
    else $error("sense flag, alert idle");
  source_alert_a: assert property (
    o_flags.source_over_flag || o_flags.source_under_flag |-> !o_alert_n)
    else $error("source flag, alert idle");
  sense_cause_a: assert property (
    $rose(o_flags.sense_over_flag) || $rose(o_flags.sense_under_flag)
    |-> $past(i_meas.sense_valid)) else $error("sense flag, no sample");
  source_cause_a: assert property (
    $rose(o_flags.source_over_flag) || $rose(o_flags.source_under_flag)
    |-> $past(i_meas.source_valid)) else $error("source flag, no sample");
  flag_sticky_a: assert property (
    $fell(o_flags.sense_over_flag) |-> $past(i_flag_clear.sense_over_flag))
    else $error("flag dropped uncleared");
  reset_pin_a: assert property (
    $fell(i_sys_rst) |-> !o_pin_oe && !o_pin_out && o_critical_out_n)
    else $error("bad state after reset");
  crit_set_a: assert property (
    $rose(o_flags.sense_crit_flag) || $rose(o_flags.source_crit_flag)
    |-> !o_critical_out_n) else $error("critical flag, line idle");
  crit_move_a: assert property (
    !$stable(o_critical_out_n)
    |-> $past(i_meas.sense_valid || i_meas.source_valid))
    else $error("critical line moved without sample");
  pin_input_a: assert property (
    $rose(o_flags.pin_change_flag) |-> !$past(o_pin_oe))
    else $error("pin change flagged as output");
endmodule
bind plg_power_limit_regs plg_chk chk_u (
  .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_meas(i_meas),
  .i_flag_clear(i_flag_clear), .o_flags(o_flags), .o_alert_n(o_alert_n),
  .o_critical_out_n(o_critical_out_n), .o_pin_out(o_pin_out),
  .o_pin_oe(o_pin_oe)
);
`default_nettype wire

//--- verification/plg_host.sv
`timescale 1ns/1ns
`default_nettype none
module plg_host (
  // bus pace and lines
  input  wire logic i_link_clock,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_scl_low,
  output logic      o_sda_low
);
  logic [8:0] rx;
  initial {o_scl_low, o_sda_low} = 2'h0;
  task automatic q;
    repeat (8) @(posedge i_link_clock);
  endtask
  // the slave may stretch the clock; bounded so a stuck line cannot hang
  task automatic hi;
    int n;
    n = 0;
    o_scl_low <= 1'b0;
    q();
    while (!i_scl && n < 5000) begin
      @(posedge i_link_clock);
      n++;
    end
  endtask
  task automatic bits(input logic [8:0] d);
    for (int i = 8; i >= 0; i--) begin
      o_sda_low <= !d[i];
      q();
      hi();
      rx = {rx[7:0], i_sda};
      q();
      o_scl_low <= 1'b1;
      q();
    end
  endtask
  task automatic start;
    o_sda_low <= 1'b0;
    q();
    hi();
    o_sda_low <= 1'b1;
    q();
    o_scl_low <= 1'b1;
    q();
  endtask
  task automatic stop;
    o_sda_low <= 1'b1;
    q();
    hi();
    o_sda_low <= 1'b0;
    q();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    bits({7'h2A, 2'h1});
    bits({a, 1'b1});
    bits({d, 1'b1});
    stop();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    bits({7'h2A, 2'h1});
    bits({a, 1'b1});
    start();
    bits({7'h2A, 2'h3});
    bits(9'h1FF);
    d = rx[8:1];
    stop();
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [7:0] STRAPS = 8'h96;
  localparam logic [7:0] RA [15] = '{8'h60, 8'h61, 8'h64, 8'h65, 8'h66,
    8'h68, 8'h69, 8'h6A, 8'h70, 8'h10, 8'hFC, 8'h4F, 8'hFD, 8'hFE, 8'hFF};
  localparam logic [7:0] RV [15] = '{8'h7F, 8'h80, 8'hFF, 8'h00, 8'h7F,
    8'hFF, 8'h0A, 8'h0A, 8'h08, 8'h00, STRAPS, STRAPS, 8'hA5, 8'h5A, 8'h01};
  // sense high byte, source high byte, expected critical line
  localparam logic [23:0] CT [8] = '{24'h7F0000, 24'h760000, 24'h750000,
    24'h740001, 24'h00FF00, 24'h7FF500, 24'h00F500, 24'h00F401};
  logic i_clock = 1'b0;
  logic lclk = 1'b0;
  logic rst = 1'b1;
  logic ext = 1'b0;
  logic scl, sda, m_scl, m_sda, s_oe, d_oe, p_out, p_oe, pin, al_n, cr_n;
  logic s_out, d_out;
  logic [3:0] pth, pdu;
  logic [7:0] v, h, l, sh, sl;
  logic [11:0] s;
  logic [10:0] u;
  plg_pkg::plg_meas_t meas = '0;
  plg_pkg::plg_flags_t flags;
  plg_pkg::plg_flags_t clr = '0;
  int seed = 53;
  int n_fail = 0;
  int checked = 0;
  always #25 i_clock = !i_clock;
  always #3 lclk = !lclk;
  // pull-ups: a released line reads high
  assign scl = !m_scl && (s_oe ? s_out : 1'b1);
  assign sda = !m_sda && (d_oe ? d_out : 1'b1);
  assign pin = p_oe ? p_out : ext;
  plg_power_limit_regs dut_u (
    .i_clock(i_clock), .i_sys_rst(rst), .i_clock_en(1'b1),
    .i_link_clock(lclk), .i_scl(scl), .o_scl_out(s_out), .o_scl_oe(s_oe),
    .i_sda(sda), .o_sda_out(d_out), .o_sda_oe(d_oe), .i_meas(meas),
    .o_flags(flags), .i_flag_clear(clr), .o_alert_n(al_n),
    .o_critical_out_n(cr_n), .i_pin(pin), .o_pin_out(p_out),
    .o_pin_oe(p_oe), .i_threshold_strap(STRAPS[7:4]),
    .i_duration_strap(STRAPS[3:0]), .o_peak_threshold_field(pth),
    .o_peak_duration_field(pdu)
  );
  plg_host host_u (.i_link_clock(lclk), .i_scl(scl), .i_sda(sda),
    .o_scl_low(m_scl), .o_sda_low(m_sda));
  function automatic logic [7:0] ef(input logic [11:0] a,
      input logic [10:0] b, input logic [7:0] hl, ll, shl, sll);
    ef = {4'h0, $signed(a[11:4]) >= $signed(hl),
      $signed(a[11:4]) < $signed(ll), b[10:3] >= shl, b[10:3] < sll};
  endfunction
  task automatic close_out;
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask
  task automatic clear;
    @(negedge i_clock);
    clr = '1;
    @(negedge i_clock);
    clr = '0;
  endtask
  task automatic samp(input logic [11:0] a, input logic [10:0] b);
    clear();
    meas = '{1'b1, a, 1'b1, b};
    @(negedge i_clock);
    meas.sense_valid = 1'b0;
    meas.source_valid = 1'b0;
  endtask
  initial begin
    #2000000;
    n_fail++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge i_clock);
    @(negedge i_clock);
    rst = 1'b0;
    repeat (8) @(negedge i_clock);
    chk({pth, pdu}, STRAPS);
    for (int i = 0; i < 15; i++) rchk(RA[i], RV[i]);
    v = 8'($random(seed));
    host_u.wr(8'hFD, v);
    rchk(8'hFD, 8'hA5);
    host_u.wr(8'h4F, ~STRAPS);
    chk({pth, pdu}, ~STRAPS);
    rchk(8'hFC, STRAPS);
    {h, l, sh, sl} = $random(seed);
    host_u.wr(8'h60, h);
    host_u.wr(8'h61, l);
    host_u.wr(8'h64, sh);
    host_u.wr(8'h65, sl);
    rchk(8'h61, l);
    for (int i = 0; i < 40; i++) begin
      {s, u} = 23'($random(seed));
      if (i == 0) {s[11:4], u[10:3]} = {h, sh};
      if (i == 1) {s[11:4], u[10:3]} = {l, sl};
      if (i == 2) {s[11:4], u[10:3]} = {l - 8'h1, sl - 8'h1};
      samp(s, u);
      v = ef(s, u, h, l, sh, sl);
      chk({4'h0, flags[6:3]}, v);
      chk({7'h0, al_n}, {7'h0, v == 8'h0});
    end
    for (int i = 0; i < 8; i++) begin
      samp({CT[i][23:16], 4'h0}, {CT[i][15:8], 3'h0});
      chk({7'h0, cr_n}, CT[i][7:0]);
      v = {6'h0, CT[i][23:16] == 8'h7F, CT[i][15:8] == 8'hFF};
      chk({6'h0, flags[2:1]}, v);
    end
    host_u.wr(8'h70, 8'h03);
    chk({6'h0, p_oe, p_out}, 8'h03);
    rchk(8'h70, 8'h07);
    ext = 1'b1;
    host_u.wr(8'h70, 8'h02);
    chk({7'h0, p_oe}, 8'h00);
    for (int m = 0; m < 2; m++) begin
      host_u.wr(8'h70, {4'h0, m[0], 3'h0});
      clear();
      ext = !ext;
      repeat (6) @(negedge i_clock);
      chk({6'h0, flags.pin_change_flag, al_n}, {7'h1, m[0]});
    end
    close_out();
  end
endmodule
`default_nettype wire
